// ---- rtl/lice_map.svh ----
// Register offsets, field positions and reset values of the interrupt
// command and error block. Definitions only; included by lice_top.
`ifndef LICE_MAP_SVH
`define LICE_MAP_SVH

// Byte offsets on the APB window
`define LICE_ADDR_W 12
`define LICE_OFF_ERROR_STATUS 12'h280
`define LICE_OFF_CMD_LOW 12'h300
`define LICE_OFF_CMD_HIGH 12'h310
`define LICE_OFF_TIMER_ENTRY 12'h320
`define LICE_OFF_THERMAL_ENTRY 12'h330

// Error status bits
`define LICE_ERR_BAD_REG 7
`define LICE_ERR_RX_BAD_VEC 6
`define LICE_ERR_TX_BAD_VEC 5
`define LICE_ERR_RX_REJECT 3
`define LICE_ERR_TX_REJECT 2

// Command low word fields
`define LICE_CMD_SHORT_HI 19
`define LICE_CMD_SHORT_LO 18
`define LICE_CMD_RREAD_LO 16
`define LICE_CMD_TRIGGER 15
`define LICE_CMD_LEVEL 14
`define LICE_CMD_PENDING 12
`define LICE_CMD_TMODE 11
`define LICE_KIND_HI 10
`define LICE_KIND_LO 8
`define LICE_VEC_HI 7
`define LICE_VEC_LO 0

// Command high word target field
`define LICE_CMD_TARGET_HI 31
`define LICE_CMD_TARGET_LO 24

// Local vector entry fields
`define LICE_ENTRY_PERIODIC 17
`define LICE_ENTRY_MASK 16
`define LICE_ENTRY_PENDING 12

// Vectors below this are illegal for fixed and lowest-priority messages
`define LICE_VEC_FIRST_LEGAL 8'h10
`define LICE_TARGET_ALL 8'hFF
`define LICE_MASK_RESET 1'h1

`endif

// ---- rtl/lice_pkg.sv ----
// Types shared by the interrupt command and error block.
// Assumes lice_map.svh supplies the numeric layout.
package lice_pkg;

    typedef enum logic [2:0] {
        KIND_FIXED = 3'h0,
        KIND_LOWEST = 3'h1,
        KIND_SYS_MGMT = 3'h2,
        KIND_REMOTE_READ = 3'h3,
        KIND_NON_MASKABLE = 3'h4,
        KIND_INIT = 3'h5,
        KIND_STARTUP = 3'h6,
        KIND_EXTERNAL = 3'h7
    } lice_kind_type;

    typedef enum logic [1:0] {
        SHORT_FIELD = 2'h0,
        SHORT_SELF = 2'h1,
        SHORT_ALL_INCL = 2'h2,
        SHORT_ALL_EXCL = 2'h3
    } lice_short_type;

    typedef enum logic [1:0] {
        RREAD_INVALID = 2'h0,
        RREAD_PENDING = 2'h1,
        RREAD_DONE = 2'h2
    } lice_rread_type;

    typedef enum {
        SEND_IDLE,
        SEND_BUSY
    } lice_send_state_type;

endpackage : lice_pkg

// ---- rtl/lice_top.sv ----
// Error status, interrupt command and timer/thermal vector entries of a
// processor-local interrupt controller, reached over APB.
// Assumes a message fabric outside that takes one send at a time and
// reports receptions as one-cycle pulses; all inputs synchronous.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lice_map.svh"

// Notes on behaviour
// - Unmapped offset access sets bad-register flag
// - Received fixed/lowest vector below 10h flagged
// - Sending fixed/lowest vector below 10h flagged
// - Received message nobody accepted sets flag
// - Sent message nobody accepted sets flag
// - Write loads and clears internal error state
// - Shorthand picks field, self, all, all-but-self
// - Broadcast shorthands force physical targeting
// - All-but-self sends all-ones target encoding
// - Remote read progress: invalid, pending, done
// - Bit 15 gives trigger kind
// - Bit 14 gives level value
// - Send pending holds until the fabric reports done
// - Bit 11 gives physical or logical targeting
// - Three-bit message kind decode
// - Bits 7..0 carry the sent vector
// - Target field used only with shorthand 00
// - Timer mode bit: one-shot or periodic
// - Masked entry raises nothing; mask resets set
// - Entry pending until local processor accepts
module lice_top
    import lice_pkg::*;
#(
    parameter int NUM_ENTRIES = 2
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic i_PSEL,
    input wire logic i_PENABLE,
    input wire logic i_PWRITE,
    input wire logic [`LICE_ADDR_W-1:0] i_PADDR,
    input wire logic [31:0] i_PWDATA,
    output logic o_PREADY,
    output logic [31:0] o_PRDATA,
    output logic o_PSLVERR,
    input wire logic [7:0] i_OWN_ID,
    output logic o_SEND_VALID,
    output logic [7:0] o_SEND_VECTOR,
    output logic [2:0] o_SEND_KIND,
    output logic o_SEND_TRIGGER,
    output logic o_SEND_LEVEL,
    output logic o_SEND_LOGICAL,
    output logic [7:0] o_SEND_TARGET,
    output logic o_SEND_EXCL_SELF,
    input wire logic i_SEND_DONE,
    input wire logic i_SEND_ACCEPTED,
    input wire logic i_SEND_READ_OK,
    input wire logic i_RX_VALID,
    input wire logic [2:0] i_RX_KIND,
    input wire logic [7:0] i_RX_VECTOR,
    input wire logic i_RX_REJECTED,
    input wire logic [NUM_ENTRIES-1:0] i_LV_EVENT,
    input wire logic [NUM_ENTRIES-1:0] i_LV_ACCEPT,
    output logic [NUM_ENTRIES-1:0] o_LV_REQ,
    output logic [NUM_ENTRIES*8-1:0] o_LV_VECTOR,
    output logic [NUM_ENTRIES*3-1:0] o_LV_KIND,
    output logic o_TIMER_PERIODIC
);

    // APB: one wait state, so read data and pready both leave flip-flops
    logic access;
    logic done;
    logic wr_done;
    logic hit_err;
    logic hit_lo;
    logic hit_hi;
    logic hit_tmr;
    logic hit_thm;
    logic mapped;
    logic pready_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;

    assign access = i_PSEL & i_PENABLE;
    assign done = access & pready_q;
    assign wr_done = done & i_PWRITE;
    assign hit_err = i_PADDR == `LICE_OFF_ERROR_STATUS;
    assign hit_lo = i_PADDR == `LICE_OFF_CMD_LOW;
    assign hit_hi = i_PADDR == `LICE_OFF_CMD_HIGH;
    assign hit_tmr = i_PADDR == `LICE_OFF_TIMER_ENTRY;
    assign hit_thm = i_PADDR == `LICE_OFF_THERMAL_ENTRY;
    assign mapped = hit_err | hit_lo | hit_hi | hit_tmr | hit_thm;

    // Command fields
    logic [7:0] vec_q;
    lice_kind_type kind_q;
    logic tmode_q;
    logic level_q;
    logic trig_q;
    lice_short_type short_q;
    logic [7:0] target_q;
    lice_rread_type rread_q;
    lice_send_state_type send_q;
    logic pending;

    // Error state
    logic [7:0] err_ev;
    logic [7:0] err_int_q;
    logic [7:0] err_reg_q;

    // Local vector entries: mask, vector, kind, pending, timer mode
    logic [NUM_ENTRIES-1:0] mask_q;
    logic [NUM_ENTRIES-1:0] lv_pend_q;
    logic [7:0] lv_vec_q [NUM_ENTRIES];
    logic [2:0] lv_kind_q [NUM_ENTRIES];
    logic [NUM_ENTRIES-1:0] lv_hit;
    logic periodic_q;

    // Timer is the first entry, thermal the last; any between stay unmapped
    always_comb begin
        lv_hit = '0;
        lv_hit[0] = hit_tmr;
        lv_hit[NUM_ENTRIES-1] = hit_thm;
    end
    assign pending = send_q == SEND_BUSY;

    // Send launch on a low-word write; refused while one is in flight
    logic launch;
    logic bad_tx;
    logic [2:0] w_kind;
    logic [7:0] w_vec;
    logic [1:0] w_short;

    assign w_kind = i_PWDATA[`LICE_KIND_HI:`LICE_KIND_LO];
    assign w_vec = i_PWDATA[`LICE_VEC_HI:`LICE_VEC_LO];
    assign w_short = i_PWDATA[`LICE_CMD_SHORT_HI:`LICE_CMD_SHORT_LO];
    assign launch = wr_done & hit_lo & ~pending;
    assign bad_tx = (w_kind == KIND_FIXED || w_kind == KIND_LOWEST)
        && w_vec < `LICE_VEC_FIRST_LEGAL;

    always_comb begin
        err_ev = 8'h00;
        err_ev[`LICE_ERR_BAD_REG] = done & ~mapped;
        err_ev[`LICE_ERR_RX_BAD_VEC] = i_RX_VALID
            && (i_RX_KIND == KIND_FIXED || i_RX_KIND == KIND_LOWEST)
            && i_RX_VECTOR < `LICE_VEC_FIRST_LEGAL;
        err_ev[`LICE_ERR_TX_BAD_VEC] = launch & bad_tx;
        err_ev[`LICE_ERR_RX_REJECT] = i_RX_VALID & i_RX_REJECTED;
        err_ev[`LICE_ERR_TX_REJECT] = pending & i_SEND_DONE & ~i_SEND_ACCEPTED;
    end

    // Events in the cycle of the loading write go to the visible copy
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            err_int_q <= 8'h00;
            err_reg_q <= 8'h00;
        end else if (wr_done && hit_err) begin
            err_reg_q <= err_int_q | err_ev;
            err_int_q <= 8'h00;
        end else begin
            err_int_q <= err_int_q | err_ev;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            vec_q <= 8'h00;
            kind_q <= KIND_FIXED;
            tmode_q <= 1'h0;
            level_q <= 1'h0;
            trig_q <= 1'h0;
            short_q <= SHORT_FIELD;
        end else if (launch) begin
            vec_q <= w_vec;
            kind_q <= lice_kind_type'(w_kind);
            tmode_q <= i_PWDATA[`LICE_CMD_TMODE];
            level_q <= i_PWDATA[`LICE_CMD_LEVEL];
            trig_q <= i_PWDATA[`LICE_CMD_TRIGGER];
            short_q <= lice_short_type'(w_short);
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            target_q <= 8'h00;
        end else if (wr_done && hit_hi) begin
            target_q <= i_PWDATA[`LICE_CMD_TARGET_HI:`LICE_CMD_TARGET_LO];
        end
    end

    // Outgoing message, held from launch until the fabric reports done
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            send_q <= SEND_IDLE;
            o_SEND_VALID <= 1'h0;
            o_SEND_VECTOR <= 8'h00;
            o_SEND_KIND <= 3'h0;
            o_SEND_TRIGGER <= 1'h0;
            o_SEND_LEVEL <= 1'h0;
            o_SEND_LOGICAL <= 1'h0;
            o_SEND_TARGET <= 8'h00;
            o_SEND_EXCL_SELF <= 1'h0;
        end else begin
            case (send_q)
                SEND_IDLE: begin
                    if (launch && !bad_tx) begin
                        send_q <= SEND_BUSY;
                        o_SEND_VALID <= 1'h1;
                        o_SEND_VECTOR <= w_vec;
                        o_SEND_KIND <= w_kind;
                        o_SEND_TRIGGER <= i_PWDATA[`LICE_CMD_TRIGGER];
                        o_SEND_LEVEL <= i_PWDATA[`LICE_CMD_LEVEL];
                        o_SEND_EXCL_SELF <= w_short == SHORT_ALL_EXCL;
                        case (lice_short_type'(w_short))
                            SHORT_FIELD: begin
                                o_SEND_TARGET <= target_q;
                                o_SEND_LOGICAL <= i_PWDATA[`LICE_CMD_TMODE];
                            end
                            SHORT_SELF: begin
                                o_SEND_TARGET <= i_OWN_ID;
                                o_SEND_LOGICAL <= 1'h0;
                            end
                            default: begin
                                o_SEND_TARGET <= `LICE_TARGET_ALL;
                                o_SEND_LOGICAL <= 1'h0;
                            end
                        endcase
                    end
                end
                SEND_BUSY: begin
                    if (i_SEND_DONE) begin
                        send_q <= SEND_IDLE;
                        o_SEND_VALID <= 1'h0;
                    end
                end
                default: begin
                    send_q <= SEND_IDLE;
                    o_SEND_VALID <= 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            rread_q <= RREAD_INVALID;
        end else if (launch && w_kind == KIND_REMOTE_READ) begin
            rread_q <= RREAD_PENDING;
        end else if (pending && i_SEND_DONE && kind_q == KIND_REMOTE_READ) begin
            rread_q <= i_SEND_READ_OK ? RREAD_DONE : RREAD_INVALID;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            periodic_q <= 1'h0;
        end else if (wr_done && hit_tmr) begin
            periodic_q <= i_PWDATA[`LICE_ENTRY_PERIODIC];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : gen_entry
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RESETN) begin
                    mask_q[g] <= `LICE_MASK_RESET;
                    lv_vec_q[g] <= 8'h00;
                    lv_kind_q[g] <= 3'h0;
                end else if (wr_done && lv_hit[g]) begin
                    mask_q[g] <= i_PWDATA[`LICE_ENTRY_MASK];
                    lv_vec_q[g] <= i_PWDATA[`LICE_VEC_HI:`LICE_VEC_LO];
                    // Timer entry carries no kind field
                    lv_kind_q[g] <= (g == 0) ? 3'h0
                        : i_PWDATA[`LICE_KIND_HI:`LICE_KIND_LO];
                end
            end

            // New event wins over a same-cycle acceptance
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RESETN) begin
                    lv_pend_q[g] <= 1'h0;
                end else if (i_LV_EVENT[g] && !mask_q[g]) begin
                    lv_pend_q[g] <= 1'h1;
                end else if (i_LV_ACCEPT[g]) begin
                    lv_pend_q[g] <= 1'h0;
                end
            end

            assign o_LV_REQ[g] = lv_pend_q[g];
            assign o_LV_VECTOR[g*8 +: 8] = lv_vec_q[g];
            assign o_LV_KIND[g*3 +: 3] = lv_kind_q[g];
        end
    endgenerate

    assign o_TIMER_PERIODIC = periodic_q;

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (hit_err) begin
            prdata_d[7:0] = err_reg_q;
        end else if (hit_lo) begin
            prdata_d[`LICE_CMD_SHORT_HI:`LICE_CMD_SHORT_LO] = short_q;
            prdata_d[`LICE_CMD_RREAD_LO +: 2] = rread_q;
            prdata_d[`LICE_CMD_TRIGGER] = trig_q;
            prdata_d[`LICE_CMD_LEVEL] = level_q;
            prdata_d[`LICE_CMD_PENDING] = pending;
            prdata_d[`LICE_CMD_TMODE] = tmode_q;
            prdata_d[`LICE_KIND_HI:`LICE_KIND_LO] = kind_q;
            prdata_d[`LICE_VEC_HI:`LICE_VEC_LO] = vec_q;
        end else if (hit_hi) begin
            prdata_d[`LICE_CMD_TARGET_HI:`LICE_CMD_TARGET_LO] = target_q;
        end else if (hit_tmr) begin
            prdata_d[`LICE_ENTRY_PERIODIC] = periodic_q;
            prdata_d[`LICE_ENTRY_MASK] = mask_q[0];
            prdata_d[`LICE_ENTRY_PENDING] = lv_pend_q[0];
            prdata_d[`LICE_VEC_HI:`LICE_VEC_LO] = lv_vec_q[0];
        end else if (hit_thm) begin
            prdata_d[`LICE_ENTRY_MASK] = mask_q[NUM_ENTRIES-1];
            prdata_d[`LICE_ENTRY_PENDING] = lv_pend_q[NUM_ENTRIES-1];
            prdata_d[`LICE_KIND_HI:`LICE_KIND_LO] = lv_kind_q[NUM_ENTRIES-1];
            prdata_d[`LICE_VEC_HI:`LICE_VEC_LO] = lv_vec_q[NUM_ENTRIES-1];
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            pready_q <= 1'h0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'h0;
        end else begin
            pready_q <= access & ~pready_q;
            prdata_q <= (access && !pready_q && !i_PWRITE) ? prdata_d : 32'h0000_0000;
            pslverr_q <= access & ~pready_q & ~mapped;
        end
    end

    assign o_PREADY = pready_q;
    assign o_PRDATA = prdata_q;
    assign o_PSLVERR = pslverr_q;

endmodule : lice_top
`default_nettype wire

// ---- sim/lice_fabric.sv ----
// Message fabric model: finishes each send after a set delay.
// Assumes one send at a time, o_SEND_VALID held until done.
`timescale 1ns/1ps
`default_nettype none
module lice_fabric (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire logic i_accept,
    input wire logic [3:0] i_delay,
    output logic o_done,
    output logic o_accepted,
    output logic o_read_ok
);
    logic [3:0] cnt_q;
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !i_valid || o_done) begin
            cnt_q <= 4'h0;
            o_done <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            o_done <= (cnt_q == i_delay);
        end
    end
    // Qualifiers are garbage outside the done pulse
    assign o_accepted = o_done ? i_accept : ~i_accept;
    assign o_read_ok = o_done ? i_accept : ~i_accept;
endmodule : lice_fabric
`default_nettype wire

// ---- sim/lice_props.sv ----
// Port checker for lice_top, bound below.
// Assumes lice_map.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "lice_map.svh"
module lice_props #(
    parameter int NUM_ENTRIES = 2
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic i_PSEL,
    input wire logic i_PENABLE,
    input wire logic i_PWRITE,
    input wire logic [11:0] i_PADDR,
    input wire logic [31:0] i_PWDATA,
    input wire logic o_PREADY,
    input wire logic o_PSLVERR,
    input wire logic [7:0] i_OWN_ID,
    input wire logic o_SEND_VALID,
    input wire logic [7:0] o_SEND_VECTOR,
    input wire logic [2:0] o_SEND_KIND,
    input wire logic o_SEND_TRIGGER,
    input wire logic o_SEND_LEVEL,
    input wire logic o_SEND_LOGICAL,
    input wire logic [7:0] o_SEND_TARGET,
    input wire logic o_SEND_EXCL_SELF,
    input wire logic i_SEND_DONE,
    input wire logic [NUM_ENTRIES-1:0] i_LV_EVENT,
    input wire logic [NUM_ENTRIES-1:0] i_LV_ACCEPT,
    input wire logic [NUM_ENTRIES-1:0] o_LV_REQ,
    input wire logic o_TIMER_PERIODIC
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    logic [31:0] hi_q;
    logic wr, mapped, legal, launch, low_wr;
    logic [7:0] exp_tgt;
    assign wr = i_PSEL && i_PENABLE && o_PREADY && i_PWRITE;
    assign mapped = i_PADDR inside {`LICE_OFF_ERROR_STATUS, `LICE_OFF_CMD_LOW,
        `LICE_OFF_CMD_HIGH, `LICE_OFF_TIMER_ENTRY, `LICE_OFF_THERMAL_ENTRY};
    assign legal = i_PWDATA[10:9] != 2'h0 || i_PWDATA[7:0] >= `LICE_VEC_FIRST_LEGAL;
    assign low_wr = wr && i_PADDR == `LICE_OFF_CMD_LOW && !o_SEND_VALID;
    assign launch = low_wr && legal;
    always_comb begin
        case (i_PWDATA[19:18])
            2'h0: exp_tgt = hi_q[31:24];
            2'h1: exp_tgt = i_OWN_ID;
            default: exp_tgt = 8'hFF;
        endcase
    end
    // Shadow of the high word, the only way to predict the target
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            hi_q <= 32'h0;
        end else if (wr && i_PADDR == `LICE_OFF_CMD_HIGH) begin
            hi_q <= i_PWDATA;
        end
    end
    a_ready_one_wait: assert property (i_PSEL && !i_PENABLE |=> !o_PREADY ##1 o_PREADY)
        else $error("ready not after one wait state");
    a_unmapped_err: assert property (o_PREADY |-> o_PSLVERR == !mapped)
        else $error("slave error wrong for address");
    a_launch_fields: assert property (launch |=> o_SEND_VALID
        && o_SEND_VECTOR == $past(i_PWDATA[7:0]) && o_SEND_KIND == $past(i_PWDATA[10:8])
        && o_SEND_TRIGGER == $past(i_PWDATA[15]) && o_SEND_LEVEL == $past(i_PWDATA[14]))
        else $error("send fields wrong at launch");
    a_target_select: assert property (launch |=> o_SEND_TARGET == $past(exp_tgt)
        && o_SEND_LOGICAL == $past(i_PWDATA[11] && i_PWDATA[19:18] == 2'h0)
        && o_SEND_EXCL_SELF == $past(i_PWDATA[19:18] == 2'h3))
        else $error("send target wrong");
    a_bad_vec_drop: assert property (low_wr && !legal |=> !o_SEND_VALID)
        else $error("illegal vector was sent");
    a_send_holds: assert property (o_SEND_VALID && !i_SEND_DONE |=> o_SEND_VALID
        && $stable(o_SEND_TARGET) && $stable(o_SEND_VECTOR))
        else $error("send dropped or changed early");
    a_send_ends: assert property (o_SEND_VALID && i_SEND_DONE |=> !o_SEND_VALID)
        else $error("send not ended after done");
    a_entry_cause: assert property ($rose(o_LV_REQ[0]) |-> $past(i_LV_EVENT[0]))
        else $error("timer request without event");
    a_entry_accept: assert property (i_LV_ACCEPT[0] && !i_LV_EVENT[0] |=> !o_LV_REQ[0])
        else $error("timer request kept after accept");
    a_timer_mode: assert property (wr && i_PADDR == `LICE_OFF_TIMER_ENTRY
        |=> o_TIMER_PERIODIC == $past(i_PWDATA[17]))
        else $error("timer mode not taken");
    c_launch: cover property (launch);
    c_done: cover property (o_SEND_VALID && i_SEND_DONE);
    c_slverr: cover property (o_PREADY && o_PSLVERR);
endmodule : lice_props
bind lice_top lice_props #(.NUM_ENTRIES(NUM_ENTRIES)) u_props (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .i_PSEL(i_PSEL), .i_PENABLE(i_PENABLE),
    .i_PWRITE(i_PWRITE), .i_PADDR(i_PADDR), .i_PWDATA(i_PWDATA), .o_PREADY(o_PREADY),
    .o_PSLVERR(o_PSLVERR), .i_OWN_ID(i_OWN_ID), .o_SEND_VALID(o_SEND_VALID),
    .o_SEND_VECTOR(o_SEND_VECTOR), .o_SEND_KIND(o_SEND_KIND),
    .o_SEND_TRIGGER(o_SEND_TRIGGER), .o_SEND_LEVEL(o_SEND_LEVEL),
    .o_SEND_LOGICAL(o_SEND_LOGICAL), .o_SEND_TARGET(o_SEND_TARGET),
    .o_SEND_EXCL_SELF(o_SEND_EXCL_SELF), .i_SEND_DONE(i_SEND_DONE),
    .i_LV_EVENT(i_LV_EVENT), .i_LV_ACCEPT(i_LV_ACCEPT), .o_LV_REQ(o_LV_REQ),
    .o_TIMER_PERIODIC(o_TIMER_PERIODIC));
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for lice_top with the fabric model.
// Assumes lice_map.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "lice_map.svh"
module testbench;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, sv;
    logic strig, slev, slog, sexcl, sdone, sacc, srok, rxv = 0, rxrej = 0, acc = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, d;
    logic [7:0] own = 8'h05, svec, stgt, rxvec = 8'h0, tg;
    logic [2:0] skind, rxk = 3'h0;
    logic [1:0] lve = 2'h0, lva = 2'h0, lvr, sh;
    logic [15:0] lvvec;
    logic [5:0] lvkind;
    logic tper, rerr;
    int failures = 0, tests_run = 0, n;
    logic [1:0] sh_tab [8] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h3, 2'h1};
    always #12.5 clk = ~clk;
    lice_top uut (.I_CLK_SYS(clk), .I_RESETN(rstn), .i_PSEL(psel), .i_PENABLE(pen),
        .i_PWRITE(pwr), .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PREADY(pready),
        .o_PRDATA(prdata), .o_PSLVERR(pslverr), .i_OWN_ID(own), .o_SEND_VALID(sv),
        .o_SEND_VECTOR(svec), .o_SEND_KIND(skind), .o_SEND_TRIGGER(strig),
        .o_SEND_LEVEL(slev), .o_SEND_LOGICAL(slog), .o_SEND_TARGET(stgt),
        .o_SEND_EXCL_SELF(sexcl), .i_SEND_DONE(sdone), .i_SEND_ACCEPTED(sacc),
        .i_SEND_READ_OK(srok), .i_RX_VALID(rxv), .i_RX_KIND(rxk), .i_RX_VECTOR(rxvec),
        .i_RX_REJECTED(rxrej), .i_LV_EVENT(lve), .i_LV_ACCEPT(lva), .o_LV_REQ(lvr),
        .o_LV_VECTOR(lvvec), .o_LV_KIND(lvkind), .o_TIMER_PERIODIC(tper));
    lice_fabric u_fab (.i_clk(clk), .i_resetn(rstn), .i_valid(sv), .i_accept(acc),
        .i_delay(4'h8), .o_done(sdone), .o_accepted(sacc), .o_read_ok(srok));
    task end_of_test;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        n = 0;
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clk) pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        {psel, pen} <= 2'b00;
        if (n >= 20) begin
            failures++;
            end_of_test();
        end
    endtask : apb
    // Latch, then read the error status
    task errs(input logic [31:0] e);
        apb(1, `LICE_OFF_ERROR_STATUS, 0);
        apb(0, `LICE_OFF_ERROR_STATUS, 0);
        chk("error_status", e, rdat);
    endtask : errs
    task ev(input logic [1:0] m);
        @(posedge clk) lve <= m;
        @(posedge clk) lve <= 2'h0;
        @(posedge clk);
    endtask : ev
    task rx(input logic [2:0] k, input logic [7:0] v, input logic rj);
        @(posedge clk) {rxv, rxk, rxvec, rxrej} <= {1'b1, k, v, rj};
        @(posedge clk) rxv <= 1'b0;
    endtask : rx
    task t_reset;
        apb(0, `LICE_OFF_TIMER_ENTRY, 0);
        chk("timer_reset", 32'h00010000, rdat);
        apb(0, `LICE_OFF_THERMAL_ENTRY, 0);
        chk("thermal_reset", 32'h00010000, rdat);
        apb(0, `LICE_OFF_CMD_LOW, 0);
        chk("low_reset", 32'h0, rdat);
    endtask : t_reset
    task t_badreg;
        apb(0, 12'h290, 0);
        chk("unmapped_read", 32'h1, {rdat[30:0], rerr});
        apb(1, 12'h3F0, 32'hFFFFFFFF);
        errs(32'h80);
        errs(32'h0);
    endtask : t_badreg
    task t_sends;
        for (int i = 0; i < 8; i++) begin
            sh = sh_tab[i];
            acc <= i[1:0] != 2'h1;
            // Only the fixed kind goes level-triggered, with level asserted
            d = {12'h0, sh, 2'h0, i == 0, i == 0, 3'h1, i[2:0], 8'h20 + i[7:0]};
            tg = sh == 2'h0 ? 8'hA0 | i[7:0] : sh == 2'h1 ? own : 8'hFF;
            apb(1, `LICE_OFF_CMD_HIGH, {8'hA0 | i[7:0], 24'h0});
            apb(1, `LICE_OFF_CMD_LOW, d);
            @(posedge clk);
            chk("send", {1'b1, d[15:14], 1'b0, d[11] && sh == 2'h0, d[10:0]},
                {sv, strig, slev, 1'b0, slog, skind, svec});
            chk("target", {sh == 2'h3, tg}, {sexcl, stgt});
            apb(0, `LICE_OFF_CMD_LOW, 0);
            // Remote read status moves only on the remote read kind (i == 3)
            chk("pending", d | 32'h1000 | (i == 3 ? 32'h10000 : i > 3 ? 32'h20000 : 32'h0), rdat);
            n = 0;
            while (sv === 1'b1 && n < 50) begin
                @(posedge clk);
                n++;
            end
            if (n >= 50) begin
                chk("send_done", 0, 1);
                end_of_test();
            end
            apb(0, `LICE_OFF_CMD_LOW, 0);
            chk("finished", d | (i >= 3 ? 32'h20000 : 32'h0), rdat);
            errs(i[1:0] == 2'h1 ? 32'h04 : 32'h0);
        end
    endtask : t_sends
    task t_badvec;
        apb(1, `LICE_OFF_CMD_LOW, 32'h0000000F);
        @(posedge clk);
        chk("fixed_low_vec", 0, sv);
        apb(1, `LICE_OFF_CMD_LOW, 32'h00000100);
        @(posedge clk);
        chk("lowest_zero_vec", 0, sv);
        errs(32'h20);
    endtask : t_badvec
    task t_rx;
        rx(3'h2, 8'h05, 0);
        errs(32'h0);
        rx(3'h1, 8'h03, 0);
        errs(32'h40);
        rx(3'h0, 8'h50, 1);
        errs(32'h08);
    endtask : t_rx
    task t_entries;
        ev(2'h3);
        chk("masked", 0, lvr);
        apb(1, `LICE_OFF_TIMER_ENTRY, 32'h00020033);
        @(posedge clk);
        chk("timer_out", 9'h133, {tper, lvvec[7:0]});
        ev(2'h1);
        chk("timer_req", 2'h1, lvr);
        apb(0, `LICE_OFF_TIMER_ENTRY, 0);
        chk("timer_pend", 32'h00021033, rdat);
        @(posedge clk) lva <= 2'h1;
        @(posedge clk) lva <= 2'h0;
        @(posedge clk);
        chk("timer_ack", 0, lvr);
        apb(1, `LICE_OFF_THERMAL_ENTRY, 32'h00000244);
        ev(2'h2);
        chk("thermal", {2'h2, 3'h2, 8'h44}, {lvr, lvkind[5:3], lvvec[15:8]});
        apb(1, `LICE_OFF_TIMER_ENTRY, 32'h00010000);
        @(posedge clk);
        chk("one_shot", 0, tper);
    endtask : t_entries
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_badreg();
        t_sends();
        t_badvec();
        t_rx();
        t_entries();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
